// ===== logic/fieldbus_virtual_io_bridge.sv
// Functional notes
// [R01] Station address comes from the rotary switch; only 1 to 63 accepted.
// [R02] Appears as a remote device station occupying two consecutive station slots.
// [R03] 24 virtual bits each way by default; extend mode raises this to 128.
// [R04] The base unit accepts at most one such bridge attached.
// [R05] After power-up or system reset, configuration loads and operation starts unprompted.
// [R06] Virtual input and output bits are exchanged with the base unit.
// [R07] Master word 0 bits 0..15 become virtual inputs 0..15.
// [R08] Master word 1 bits 0..7 become virtual inputs 16..23; bits 8..15 unused.
// [R09] Virtual outputs 0..15 go to station word 0 bits 0..15.
// [R10] Virtual outputs 16..23 go to station word 1 bits 0..7; bits 8..15 unused.
// [R11] Indicators for supply power, running operation and link error are driven.
// [R12] Unused station bits are sent as zero; unused master bits are ignored.
`timescale 1ns/1ps
module fieldbus_virtual_io_bridge
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Configuration straps
  input  wire logic [fbio_pkg::SWITCH_W-1:0] switch_address,
  input  wire logic                          extend_mode,
  // Fieldbus link side
  input  wire logic                          fb_link_up,
  input  wire logic                          fb_ry_valid,
  input  wire logic [fbio_pkg::FB_BITS-1:0]  fb_ry_data,
  output logic      [fbio_pkg::FB_BITS-1:0]  fb_rx_data,
  output logic      [fbio_pkg::ADDR_W-1:0]   fb_station_address,
  output logic      [1:0]                    fb_station_count,
  output logic      [1:0]                    fb_station_type,
  output logic                               fb_online,
  // Base unit jumper side
  input  wire logic                          virtual_output_valid,
  input  wire logic [fbio_pkg::EXT_BITS-1:0] virtual_output_bits,
  output logic                               virtual_input_valid,
  output logic      [fbio_pkg::EXT_BITS-1:0] virtual_input_bits,
  // Indicators
  output logic                               led_power,
  output logic                               led_run,
  output logic                               led_link_error
);

  fbio_pkg::bridge_state_t           state_reg;
  fbio_pkg::bridge_state_t           state_next;
  logic [fbio_pkg::ADDR_W-1:0]       addr_reg;
  logic [fbio_pkg::ADDR_W-1:0]       addr_next;
  logic                              ext_reg;
  logic                              ext_next;
  logic [fbio_pkg::EXT_BITS-1:0]     vin_reg;
  logic [fbio_pkg::EXT_BITS-1:0]     vin_next;
  logic                              vin_valid_reg;
  logic                              vin_valid_next;
  logic [fbio_pkg::FB_BITS-1:0]      rx_reg;
  logic [fbio_pkg::FB_BITS-1:0]      rx_next;

  function automatic logic addr_ok(input logic [fbio_pkg::SWITCH_W-1:0] a);
    addr_ok = (a >= fbio_pkg::ADDR_MIN) && (a <= fbio_pkg::ADDR_MAX); // R01
  endfunction

  // Master-to-station area into virtual inputs. Bits 8..15 of word 1 are dropped.
  function automatic logic [fbio_pkg::EXT_BITS-1:0] map_in(input logic [fbio_pkg::FB_BITS-1:0] d,
                                                          input logic ext);
    logic [fbio_pkg::EXT_BITS-1:0] r;
    r = fbio_pkg::VIN_RESET;
    r[fbio_pkg::W0_MSB:fbio_pkg::W0_LSB] = d[fbio_pkg::W0_MSB:fbio_pkg::W0_LSB]; // R07
    r[fbio_pkg::BASE_BITS-1:fbio_pkg::W1_LSB] = d[fbio_pkg::W1_USED_MSB:fbio_pkg::W1_LSB]; // R08
    if (ext)
    begin
      r[fbio_pkg::EXT_BITS-1:fbio_pkg::BASE_BITS] = d[fbio_pkg::EXT_FB_MSB:fbio_pkg::EXT_FB_LSB]; // R03
    end
    map_in = r; // R12
  endfunction

  // Virtual outputs into the station-to-master area; everything unused stays zero.
  function automatic logic [fbio_pkg::FB_BITS-1:0] map_out(input logic [fbio_pkg::EXT_BITS-1:0] v,
                                                          input logic ext);
    logic [fbio_pkg::FB_BITS-1:0] r;
    r = fbio_pkg::RX_RESET; // R12
    r[fbio_pkg::W0_MSB:fbio_pkg::W0_LSB] = v[fbio_pkg::W0_MSB:fbio_pkg::W0_LSB]; // R09
    r[fbio_pkg::W1_USED_MSB:fbio_pkg::W1_LSB] = v[fbio_pkg::BASE_BITS-1:fbio_pkg::W1_LSB]; // R10
    if (ext)
    begin
      r[fbio_pkg::EXT_FB_MSB:fbio_pkg::EXT_FB_LSB] = v[fbio_pkg::EXT_BITS-1:fbio_pkg::BASE_BITS]; // R03
    end
    map_out = r;
  endfunction

  // Straps are caught by the clock after reset release, so a switch turned
  // while running has no effect until the next system reset.
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    ext_next = ext_reg;
    vin_next = vin_reg;
    vin_valid_next = 1'b0;
    rx_next = rx_reg;
    case (state_reg)
      fbio_pkg::ST_LOAD:
      begin
        addr_next = switch_address[fbio_pkg::ADDR_W-1:0];
        ext_next = extend_mode; // R03
        if (addr_ok(switch_address)) // R01
        begin
          state_next = fbio_pkg::ST_RUN; // R05
        end
        else
        begin
          state_next = fbio_pkg::ST_ADDR_ERR;
        end
      end
      fbio_pkg::ST_RUN:
      begin
        if (fb_ry_valid)
        begin
          vin_next = map_in(fb_ry_data, ext_reg); // R06
          vin_valid_next = 1'b1;
        end
        if (virtual_output_valid)
        begin
          rx_next = map_out(virtual_output_bits, ext_reg); // R06
        end
      end
      fbio_pkg::ST_ADDR_ERR:
      begin
        state_next = fbio_pkg::ST_ADDR_ERR;
      end
      default:
      begin
        state_next = fbio_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= fbio_pkg::ST_LOAD; // R05
      addr_reg <= '0;
      ext_reg <= 1'b0;
      vin_reg <= fbio_pkg::VIN_RESET;
      vin_valid_reg <= 1'b0;
      rx_reg <= fbio_pkg::RX_RESET;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      ext_reg <= ext_next;
      vin_reg <= vin_next;
      vin_valid_reg <= vin_valid_next;
      rx_reg <= rx_next;
    end
  end

  assign fb_rx_data = rx_reg;
  assign fb_station_address = addr_reg; // R01
  assign fb_station_count = fbio_pkg::STATIONS_OCCUPIED; // R02
  assign fb_station_type = fbio_pkg::STATION_TYPE_REMOTE_DEVICE; // R02
  assign fb_online = (state_reg == fbio_pkg::ST_RUN);
  assign virtual_input_bits = vin_reg;
  assign virtual_input_valid = vin_valid_reg;
  // The power indicator only tells that logic is supplied, so it is held on.
  assign led_power = 1'b1; // R11
  assign led_run = fb_online && fb_link_up; // R11
  assign led_link_error = (state_reg == fbio_pkg::ST_ADDR_ERR) || (fb_online && !fb_link_up); // R11

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_addr_accept;
    (state_reg == fbio_pkg::ST_LOAD) && addr_ok(switch_address)
      |=> fb_online && (fb_station_address == $past(switch_address[fbio_pkg::ADDR_W-1:0]));
  endproperty
  a_addr_accept: assert property (p_addr_accept) else $error("valid address not accepted"); // R01

  property p_addr_reject;
    (state_reg == fbio_pkg::ST_LOAD) && !addr_ok(switch_address) |=> (!fb_online && led_link_error) [*2];
  endproperty
  a_addr_reject: assert property (p_addr_reject) else $error("bad address not rejected"); // R01

  property p_stations;
    fb_station_count == fbio_pkg::STATIONS_OCCUPIED && fb_station_type == fbio_pkg::STATION_TYPE_REMOTE_DEVICE;
  endproperty
  a_stations: assert property (p_stations) else $error("station identity wrong"); // R02

  property p_base_only;
    !ext_reg |-> virtual_input_bits[127:24] == '0 && fb_rx_data[143:32] == '0;
  endproperty
  a_base_only: assert property (p_base_only) else $error("extended bits used in base mode"); // R03

  property p_auto_start;
    $past(rst) |-> (state_reg == fbio_pkg::ST_LOAD) ##1 (state_reg != fbio_pkg::ST_LOAD);
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no automatic start after reset"); // R05

  property p_in_low;
    fb_online && fb_ry_valid
      |=> virtual_input_valid && virtual_input_bits[15:0] == $past(fb_ry_data[15:0]);
  endproperty
  a_in_low: assert property (p_in_low) else $error("input word 0 mismapped"); // R07

  property p_in_high;
    fb_online && fb_ry_valid |=> virtual_input_bits[23:16] == $past(fb_ry_data[23:16]);
  endproperty
  a_in_high: assert property (p_in_high) else $error("input word 1 mismapped"); // R08

  property p_out_map;
    fb_online && virtual_output_valid
      |=> fb_rx_data[15:0] == $past(virtual_output_bits[15:0])
          && fb_rx_data[23:16] == $past(virtual_output_bits[23:16]);
  endproperty
  a_out_map: assert property (p_out_map) else $error("output words mismapped"); // R09

  property p_out_unused;
    fb_rx_data[31:24] == 8'h00 && fb_rx_data[143:136] == 8'h00;
  endproperty
  a_out_unused: assert property (p_out_unused) else $error("unused output bits not zero"); // R10

  property p_led_link;
    fb_online && !fb_link_up |-> led_link_error && !led_run && led_power;
  endproperty
  a_led_link: assert property (p_led_link) else $error("link error indicator wrong"); // R11

  property p_in_hold;
    fb_online && !fb_ry_valid |=> !virtual_input_valid && $stable(virtual_input_bits);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("inputs changed without frame"); // R06

  c_run_frame: cover property (fb_online && fb_ry_valid ##1 virtual_input_valid);
  c_ext_out: cover property (fb_online && ext_reg && virtual_output_valid);
  c_addr_err: cover property (state_reg == fbio_pkg::ST_ADDR_ERR);

endmodule // fieldbus_virtual_io_bridge

// ===== logic/fbio_pkg.sv
package fbio_pkg;

  // Station address window of the rotary switch.
  localparam logic [6:0] ADDR_MIN = 7'h01;
  localparam logic [6:0] ADDR_MAX = 7'h3f;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned SWITCH_W = 7;

  // Station identity on the fieldbus.
  localparam logic [1:0] STATIONS_OCCUPIED = 2'h2;
  // Code for a remote device station; the value is arbitrary.
  localparam logic [1:0] STATION_TYPE_REMOTE_DEVICE = 2'h1;

  // Virtual bit counts per direction.
  localparam int unsigned BASE_BITS = 24;
  localparam int unsigned EXT_BITS = 128;

  // Fieldbus cyclic area: nine 16-bit words per direction.
  localparam int unsigned FB_WORD = 16;
  localparam int unsigned FB_WORDS = 9;
  localparam int unsigned FB_BITS = FB_WORD * FB_WORDS;

  // Field positions of the cyclic area.
  localparam int unsigned W0_LSB = 0;
  localparam int unsigned W0_MSB = 15;
  localparam int unsigned W1_LSB = 16;
  localparam int unsigned W1_USED_MSB = 23;
  localparam int unsigned W1_MSB = 31;
  localparam int unsigned EXT_FB_LSB = 32;
  localparam int unsigned EXT_FB_MSB = EXT_FB_LSB + EXT_BITS - BASE_BITS - 1;

  // Reset values.
  localparam logic [EXT_BITS-1:0] VIN_RESET = 128'h0;
  localparam logic [FB_BITS-1:0] RX_RESET = 144'h0;

  typedef enum logic [2:0] {
    ST_LOAD     = 3'b001,
    ST_RUN      = 3'b010,
    ST_ADDR_ERR = 3'b100
  } bridge_state_t;

endpackage

// ===== bench/fb_master_model.sv
`timescale 1ns/1ps
module fb_master_model
(
  // Clock
  input  wire logic                         clk,
  // Frame request
  input  wire logic                         send,
  input  wire logic [fbio_pkg::FB_BITS-1:0] frame,
  // Fieldbus side
  output logic                              fb_ry_valid,
  output logic      [fbio_pkg::FB_BITS-1:0] fb_ry_data
);
  // Between frames the data is inverted on every clock, so stale data cannot pass for fresh.
  // One process owns both outputs, so they have a single driver from time zero on.
  initial
  begin
    fb_ry_valid = 1'b0;
    fb_ry_data = '0;
    forever
    begin
      @(posedge clk);
      fb_ry_valid <= send;
      fb_ry_data <= send ? frame : ~fb_ry_data;
    end
  end
endmodule // fb_master_model

// ===== bench/test_fieldbus_virtual_io_bridge.sv
`timescale 1ns/1ps
module test_fieldbus_virtual_io_bridge;
  logic         clk, rst, extend_mode, fb_link_up, send, vov, ok;
  logic [6:0]   switch_address;
  logic [143:0] frame, fb_ry_data, fb_rx_data, d, exp_rx;
  logic         fb_ry_valid, fb_online, virtual_input_valid, led_power, led_run, led_link_error;
  logic [127:0] vob, virtual_input_bits;
  logic [5:0]   fb_station_address;
  logic [1:0]   fb_station_count, fb_station_type;
  logic [143:0] exp_q[$];
  int           errors, n_tests;
  logic [6:0]   addrs[4] = '{7'h01, 7'h3f, 7'h00, 7'h40};
  logic         exts[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  fb_master_model master (.clk(clk), .send(send), .frame(frame), .fb_ry_valid(fb_ry_valid), .fb_ry_data(fb_ry_data));
  fieldbus_virtual_io_bridge DUT (.clk(clk), .rst(rst), .switch_address(switch_address), .extend_mode(extend_mode),
    .fb_link_up(fb_link_up), .fb_ry_valid(fb_ry_valid), .fb_ry_data(fb_ry_data), .fb_rx_data(fb_rx_data),
    .fb_station_address(fb_station_address), .fb_station_count(fb_station_count),
    .fb_station_type(fb_station_type), .fb_online(fb_online), .virtual_output_valid(vov),
    .virtual_output_bits(vob), .virtual_input_valid(virtual_input_valid),
    .virtual_input_bits(virtual_input_bits), .led_power(led_power), .led_run(led_run),
    .led_link_error(led_link_error));

  function automatic logic [143:0] rnd();
    logic [159:0] r;
    for (int i = 0; i < 5; i++)
      r = {r[127:0], 32'($urandom)};
    return r[143:0];
  endfunction

  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A valid with nothing expected means a frame was taken while it should have been refused.
  always @(posedge clk)
    if (virtual_input_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(144'h1, 144'h0);
      else
        check({16'h0, virtual_input_bits}, exp_q.pop_front());
    end

  initial
  begin
    rst = 1'b1;
    switch_address = 7'h01;
    extend_mode = 1'b0;
    fb_link_up = 1'b1;
    send = 1'b0;
    frame = '0;
    vov = 1'b0;
    vob = '0;
    errors = 0;
    n_tests = 0;
    void'($urandom(65549));
    for (int c = 0; c < 4; c++)
    begin
      ok = addrs[c] >= 7'h01 && addrs[c] <= 7'h3f;
      @(posedge clk);
      rst <= 1'b1;
      switch_address <= addrs[c];
      extend_mode <= exts[c];
      repeat (c == 0 ? 3 : 4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(fb_online, ok);
      check(led_link_error, !ok);
      check(led_run, ok);
      check(led_power, 1'b1);
      if (ok)
        check(fb_station_address, addrs[c][5:0]);
      check(fb_station_count, fbio_pkg::STATIONS_OCCUPIED);
      check(fb_station_type, fbio_pkg::STATION_TYPE_REMOTE_DEVICE);
      exp_rx = '0;
      check(fb_rx_data, exp_rx);
      for (int k = 0; k < 3; k++)
      begin
        @(posedge clk);
        d = rnd();
        send <= 1'b1;
        frame <= d;
        if (ok)
          exp_q.push_back({16'h0, exts[c] ? d[135:32] : 104'h0, d[23:0]});
      end
      @(posedge clk);
      send <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
        @(posedge clk);
        d = rnd();
        vov <= 1'b1;
        vob <= d[127:0];
        if (ok)
          exp_rx = {8'h0, exts[c] ? d[127:24] : 104'h0, 8'h0, d[23:0]};
        @(posedge clk);
        vov <= 1'b0;
        vob <= ~d[127:0];
        #1;
        check(fb_rx_data, exp_rx);
      end
      @(posedge clk);
      fb_link_up <= 1'b0;
      @(posedge clk);
      #1;
      check(led_run, 1'b0);
      check(led_link_error, 1'b1);
      @(posedge clk);
      fb_link_up <= 1'b1;
      for (int w = 0; w < 20 && exp_q.size() > 0; w++)
        @(posedge clk);
      if (exp_q.size() > 0)
        check(144'h1, 144'h0);
    end
    results();
  end
endmodule // test_fieldbus_virtual_io_bridge
